// *** stcp_command_port.sv ***
// serial terminal command port: uart receive/transmit, line buffer, command decode
// assumes rxd is an asynchronous pin; instrument core answers on actions and meas
// What this block does
// - the link runs 9600 baud, 8 data bits, 1 stop bit, no parity, with xon/xoff flow control.
// - a command is one or more lower-case letters optionally followed by parameter characters.
// - a buffered command is acted upon only after a carriage return arrives.
// - the beep command with its terminator gives one beeper pulse.
// - the light-on command switches actinic light on and the light-off command switches it off.
// - the saturation-pulse command triggers one saturation pulse with its measurement.
// - the two read commands return steady and peak fluorescence from the latest pulse.
module stcp_command_port
  import stcp_pkg::*;
#(
  parameter int unsigned DEPTH = LINE_DEPTH,
  parameter int unsigned BIT_LEN = BIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // serial pins
  input wire logic rxd,
  output logic txd,
  // instrument side
  input wire stcp_meas_s meas,
  output stcp_act_s actions,
  output logic cmdError
);
  localparam int AW = $clog2(DEPTH);
  // bit time is a parameter so a short divider can stand in for the 9600 baud default
  localparam logic [15:0] BIT_CNT = 16'(BIT_LEN);
  localparam logic [15:0] HALF_CNT = 16'(BIT_LEN / 2);
  localparam logic [3:0] FRAME_BITS = 4'(DATA_BITS + STOP_BITS);

  typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_READ = 2'b01, PS_EXEC = 2'b11, PS_SEND = 2'b10} stcp_ps_e;

  function automatic logic isLower(input logic [7:0] c);
    return (c >= CH_LOW_A) && (c <= CH_LOW_Z);
  endfunction

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    return (n < 4'hA) ? 8'(CH_0 + 8'(n)) : 8'(CH_A + 8'(n - 4'hA));
  endfunction

  // input synchroniser, two flops before any use
  logic rxMeta, rxSync;
  always_ff @(posedge mclk) begin
    rxMeta <= rxd;
    rxSync <= rxMeta;
  end

  // receiver: sample mid-bit, lsb first, one stop bit, no parity
  logic rxBusy;
  logic [15:0] rxTimer;
  logic [3:0] rxBit;
  logic [7:0] rxShift;
  logic rxDone;
  wire rxTick = (rxTimer == 16'h0000);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rxBusy <= 1'b0;
      rxTimer <= 16'h0000;
      rxBit <= 4'h0;
      rxShift <= 8'h00;
      rxDone <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (!rxBusy) begin
        if (!rxSync) begin
          rxBusy <= 1'b1;
          rxTimer <= HALF_CNT;
          rxBit <= 4'h0;
        end
      end else if (!rxTick) begin
        rxTimer <= rxTimer - 16'h0001;
      end else begin
        rxTimer <= BIT_CNT - 16'h0001;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxSync) begin
          rxBusy <= 1'b0; // false start, glitch ignored
        end else if (rxBit == FRAME_BITS) begin
          rxBusy <= 1'b0;
          rxDone <= rxSync; // framing error drops the character
        end else begin
          rxShift <= {rxSync, rxShift[7:1]};
        end
      end
    end
  end

  // xon/xoff from the host pauses our transmitter
  logic txPaused;
  wire isFlow = (rxShift == CH_XON) || (rxShift == CH_XOFF);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      txPaused <= 1'b0;
    end else if (rxDone && rxShift == CH_XOFF) begin
      txPaused <= 1'b1;
    end else if (rxDone && rxShift == CH_XON) begin
      txPaused <= 1'b0;
    end
  end

  // line collection; overlong lines are flagged bad and dropped at the terminator
  stcp_ps_e state;
  logic [AW:0] lineLen;
  logic lineBad;
  logic [AW-1:0] rdAddr;
  logic [7:0] rdData;
  wire isCr = rxDone && (rxShift == CH_CR);
  wire storeChar = rxDone && !isFlow && !isCr && (rxShift != CH_LF) && (state == PS_IDLE);
  wire lineFull = (lineLen == (AW+1)'(DEPTH));

  stcp_line_mem #(.DEPTH(DEPTH)) lineMem (
    .mclk(mclk),
    .wrEn(storeChar && !lineFull),
    .wrAddr(lineLen[AW-1:0]),
    .wrData(rxShift),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  // read-back of stored line into a small match window
  logic [7:0] c0, c1, c2;
  logic [AW:0] rdCount;
  wire [AW:0] scanLen = (lineLen > (AW+1)'(3)) ? (AW+1)'(3) : lineLen;

  // decode of the collected characters
  wire known2 = (lineLen == (AW+1)'(2));
  wire isBeep = known2 && c0 == CH_B && c1 == CH_P;
  wire isLightOn = known2 && c0 == CH_A && c1 == CH_1;
  wire isLightOff = known2 && c0 == CH_A && c1 == CH_0;
  wire isSat = (lineLen == (AW+1)'(1)) && c0 == CH_S;
  wire isReadF = (lineLen == (AW+1)'(1)) && c0 == CH_F;
  wire isReadFm = (lineLen == (AW+1)'(3)) && c0 == CH_F && c1 == CH_M && c2 == CH_P;
  wire firstOk = isLower(c0);
  stcp_cmd_e decoded;
  assign decoded = (lineBad || !firstOk) ? CMD_NONE :
                   isBeep ? CMD_BEEP : isLightOn ? CMD_LIGHT_ON : isLightOff ? CMD_LIGHT_OFF :
                   isSat ? CMD_SAT : isReadF ? CMD_READ_F : isReadFm ? CMD_READ_FM : CMD_NONE;

  // reply buffer: four hex digits then cr lf
  logic [VAL_W-1:0] replyVal;
  logic [2:0] replyIdx;
  logic txBusy;
  logic txStart;
  logic [7:0] txChar;
  wire [7:0] replyChar = (replyIdx == 3'd4) ? CH_CR : (replyIdx == 3'd5) ? CH_LF :
                         hexChar(replyVal[VAL_W-1 -: 4]);

  // command sequencer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= PS_IDLE;
      lineLen <= '0;
      lineBad <= 1'b0;
      rdAddr <= '0;
      rdCount <= '0;
      c0 <= 8'h00;
      c1 <= 8'h00;
      c2 <= 8'h00;
      actions <= '0;
      cmdError <= 1'b0;
      replyVal <= '0;
      replyIdx <= 3'd0;
      txStart <= 1'b0;
      txChar <= 8'h00;
    end else begin
      actions.beep <= 1'b0;
      actions.satPulse <= 1'b0;
      cmdError <= 1'b0;
      txStart <= 1'b0;
      case (state)
        PS_IDLE: begin
          if (storeChar) begin
            if (lineFull) begin
              lineBad <= 1'b1;
            end else begin
              lineLen <= lineLen + (AW+1)'(1);
            end
          end else if (isCr && state == PS_IDLE) begin
            state <= PS_READ; // act only after the terminator
            rdAddr <= '0;
            rdCount <= '0;
            c0 <= 8'h00;
            c1 <= 8'h00;
            c2 <= 8'h00;
          end
        end
        PS_READ: begin
          // memory read is registered, data lags the address by one cycle
          if (rdCount != '0) begin
            if (rdCount == (AW+1)'(1)) c0 <= rdData;
            if (rdCount == (AW+1)'(2)) c1 <= rdData;
            if (rdCount == (AW+1)'(3)) c2 <= rdData;
          end
          if (rdCount >= scanLen) begin
            state <= PS_EXEC;
          end
          rdAddr <= rdAddr + AW'(1);
          rdCount <= rdCount + (AW+1)'(1);
        end
        PS_EXEC: begin
          lineLen <= '0;
          lineBad <= 1'b0;
          state <= PS_IDLE;
          case (decoded)
            CMD_BEEP: actions.beep <= 1'b1;
            CMD_LIGHT_ON: actions.lightOn <= 1'b1;
            CMD_LIGHT_OFF: actions.lightOn <= 1'b0;
            CMD_SAT: actions.satPulse <= 1'b1;
            CMD_READ_F, CMD_READ_FM: begin
              replyVal <= (decoded == CMD_READ_F) ? meas.steady : meas.peak;
              replyIdx <= 3'd0;
              state <= PS_SEND;
            end
            default: cmdError <= (lineLen != '0); // nothing else changes
          endcase
        end
        PS_SEND: begin
          // characters arriving meanwhile are lost, except xon/xoff, which still act; host waits for the reply
          if (!txBusy && !txStart && !txPaused) begin
            txChar <= replyChar;
            txStart <= 1'b1;
            if (replyIdx < 3'd4) replyVal <= {replyVal[VAL_W-5:0], 4'h0};
            if (replyIdx == 3'(REPLY_LEN - 1)) state <= PS_IDLE;
            replyIdx <= replyIdx + 3'd1;
          end
        end
        default: state <= PS_IDLE;
      endcase
    end
  end

  // transmitter: start bit, 8 data lsb first, one stop bit
  logic [15:0] txTimer;
  logic [3:0] txBit;
  logic [8:0] txShift;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      txBusy <= 1'b0;
      txd <= 1'b1;
      txTimer <= 16'h0000;
      txBit <= 4'h0;
      txShift <= 9'h1FF;
    end else if (!txBusy) begin
      if (txStart) begin
        txBusy <= 1'b1;
        txd <= 1'b0;
        txShift <= {1'b1, txChar};
        txTimer <= BIT_CNT - 16'h0001;
        txBit <= 4'h0;
      end
    end else if (txTimer != 16'h0000) begin
      txTimer <= txTimer - 16'h0001;
    end else if (txBit == FRAME_BITS) begin
      txBusy <= 1'b0;
    end else begin
      txd <= txShift[0];
      txShift <= {1'b1, txShift[8:1]};
      txBit <= txBit + 4'h1;
      txTimer <= BIT_CNT - 16'h0001;
    end
  end
endmodule

// *** stcp_pkg.sv ***
// package for the serial terminal command port: link timing, characters, carriers
// assumes a single 10 MHz clock; all other blocks import this whole package
package stcp_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam int unsigned LINE_DEPTH = 16;
  localparam int unsigned VAL_W = 16;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CH_B = 8'h62;
  localparam logic [7:0] CH_P = 8'h70;
  localparam logic [7:0] CH_A = 8'h61;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_S = 8'h73;
  localparam logic [7:0] CH_F = 8'h66;
  localparam logic [7:0] CH_M = 8'h6D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam int unsigned REPLY_LEN = 6;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_BEEP = 3'h1,
    CMD_LIGHT_ON = 3'h2,
    CMD_LIGHT_OFF = 3'h3,
    CMD_SAT = 3'h4,
    CMD_READ_F = 3'h5,
    CMD_READ_FM = 3'h6
  } stcp_cmd_e;

  // fluorescence results captured by the measuring core after a pulse
  typedef struct packed {
    logic valid;
    logic [VAL_W-1:0] steady;
    logic [VAL_W-1:0] peak;
  } stcp_meas_s;

  // instrument actions requested by the command port
  typedef struct packed {
    logic beep;
    logic satPulse;
    logic lightOn;
  } stcp_act_s;
endpackage

// *** stcp_line_mem.sv ***
// small line buffer holding the characters of one command until the terminator
// assumes writer and reader in the same clock domain; read data is registered
module stcp_line_mem
  import stcp_pkg::*;
#(
  parameter int unsigned DEPTH = LINE_DEPTH
) (
  // clock
  input wire logic mclk,
  // write side
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];

  // no reset on storage; contents only matter below the stored length
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// *** stcp_port_checker.sv ***
// checker for the serial terminal command port: action pulses, light level, reset state
// assumes it is bound to stcp_command_port and sees only that module's ports
module stcp_port_checker
  import stcp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // serial pins
  input wire logic rxd,
  input wire logic txd,
  // instrument side
  input wire stcp_meas_s meas,
  input wire stcp_act_s actions,
  input wire logic cmdError
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // pulses stand one cycle; the light only moves on its own commands
  a_reset_quiet: assert property ($rose(resetn) |-> actions == 3'h0 && txd && !cmdError)
    else $error("outputs not idle after reset");
  a_beep_single: assert property (actions.beep |=> !actions.beep)
    else $error("beep longer than one cycle");
  a_sat_single: assert property (actions.satPulse |=> !actions.satPulse)
    else $error("saturation pulse longer than one cycle");
  a_error_single: assert property (cmdError |=> !cmdError)
    else $error("error pulse longer than one cycle");
  a_error_keeps_light: assert property (cmdError |-> $stable(actions.lightOn))
    else $error("unknown line moved the light");
  a_one_effect: assert property ($onehot0({actions.beep, actions.satPulse, cmdError, $changed(actions.lightOn)}))
    else $error("two effects from one line");
  // effects come inside the stop bit, so the line has been high for a while
  a_act_after_stop: assert property ((actions.beep || actions.satPulse || cmdError || $changed(actions.lightOn))
    |-> rxd && $past(rxd, 4) && $past(rxd, 8))
    else $error("effect before the terminator stop bit");
  a_quiet_midchar: assert property (!rxd |-> !actions.beep && !actions.satPulse && $stable(actions.lightOn))
    else $error("effect while a character is in flight");
  cover property (actions.beep);
  cover property (actions.satPulse);
  cover property (cmdError);
  cover property ($rose(actions.lightOn));
  cover property ($fell(actions.lightOn));
endmodule

bind stcp_command_port stcp_port_checker u_chk (.mclk(mclk), .resetn(resetn), .rxd(rxd), .txd(txd),
  .meas(meas), .actions(actions), .cmdError(cmdError));

// *** stcp_host_model.sv ***
// host terminal model: sends characters on rxd, decodes characters coming back on txd
// assumes the bench calls send_char by hierarchical name and uses the same bit time as the port
module stcp_host_model
  import stcp_pkg::*;
#(
  parameter int unsigned BIT_LEN = BIT_CYCLES
) (
  // clock
  input wire logic mclk,
  // serial pins
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int rxCount = 0;
  int rxBad = 0;
  logic [7:0] rxBuf [12];
  initial rxd = 1'b1; // idle line is high
  // take one reply character at mid-bit; later edges inside the frame are ignored while busy
  always @(negedge txd) begin
    logic [7:0] got;
    repeat (BIT_LEN / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_LEN) @(posedge mclk);
      got[i] = txd;
    end
    repeat (BIT_LEN) @(posedge mclk);
    if (txd !== 1'b1) rxBad++;
    if (rxCount < 12) rxBuf[rxCount] = got;
    rxCount++;
  end
  // one frame: start, eight data bits lsb first, one stop, no parity
  task automatic send_char(input logic [7:0] c);
    logic [9:0] frame;
    frame = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      rxd <= frame[i];
      repeat (BIT_LEN - 1) @(posedge mclk);
    end
  endtask
endmodule

// *** tb.sv ***
// self-checking bench for the serial terminal command port
// assumes the host model drives rxd and the checker is bound to the port
module tb
  import stcp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [0:2][7:0] text;
    int len;
    logic [7:0] beeps;
    logic [7:0] sats;
    logic [7:0] errs;
    logic light;
  } stcp_row_s;
  localparam int unsigned BIT_LEN = 32; // short bit time keeps the run small; the dividers scale with it
  localparam int LIMIT = 40000; // about fifty frames of 320 cycles plus reply waits, with margin
  // line sent, then what it adds to the pulse counts and the light level after it
  stcp_row_s rows [8] = '{
    '{{CH_B, CH_P, 8'h00}, 2, 8'h01, 8'h00, 8'h00, 1'b0},
    '{{CH_A, CH_1, 8'h00}, 2, 8'h00, 8'h00, 8'h00, 1'b1},
    '{{CH_S, 8'h00, 8'h00}, 1, 8'h00, 8'h01, 8'h00, 1'b1},
    '{{8'h78, 8'h00, 8'h00}, 1, 8'h00, 8'h00, 8'h01, 1'b1},
    '{{CH_A, CH_0, 8'h00}, 2, 8'h00, 8'h00, 8'h00, 1'b0},
    '{{CH_B, 8'h00, 8'h00}, 1, 8'h00, 8'h00, 8'h01, 1'b0},
    '{{8'h41, CH_1, 8'h00}, 2, 8'h00, 8'h00, 8'h01, 1'b0},
    '{{8'h00, 8'h00, 8'h00}, 0, 8'h00, 8'h00, 8'h00, 1'b0}
  };
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic txd;
  logic rxd;
  stcp_meas_s meas = {1'b1, 16'h1234, 16'hABCD};
  stcp_act_s actions;
  logic cmdError;
  logic [7:0] nB = 8'h00;
  logic [7:0] nS = 8'h00;
  logic [7:0] nE = 8'h00;
  logic [7:0] eB = 8'h00;
  logic [7:0] eS = 8'h00;
  logic [7:0] eE = 8'h00;
  logic eL = 1'b0;
  // replies for the fixed measurement: steady 1234, peak abcd, lower-case hex then cr lf
  logic [7:0] fReply [6] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h0D, 8'h0A};
  logic [7:0] fmReply [6] = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h0D, 8'h0A};
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;

  stcp_command_port #(.DEPTH(LINE_DEPTH), .BIT_LEN(BIT_LEN)) u_dut (.mclk(mclk), .resetn(resetn), .rxd(rxd),
    .txd(txd), .meas(meas), .actions(actions), .cmdError(cmdError));
  stcp_host_model #(.BIT_LEN(BIT_LEN)) u_host (.mclk(mclk), .txd(txd), .rxd(rxd));

  always #50 mclk = ~mclk;
  // tally pulses on the falling edge, where outputs have settled; a count also catches doubled pulses
  always @(negedge mclk) begin
    if (actions.beep === 1'b1) nB++;
    if (actions.satPulse === 1'b1) nS++;
    if (cmdError === 1'b1) nE++;
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_all();
    chk("beeps", eB, nB);
    chk("pulses", eS, nS);
    chk("errors", eE, nE);
    chk("light", {7'h0, eL}, {7'h0, actions.lightOn});
  endtask

  // wait until the host has taken n reply characters; a hang ends in the timeout
  task automatic wait_replies(input int n);
    while (u_host.rxCount < n) @(posedge mclk);
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    chk("txd", 8'h01, {7'h0, txd});
    chk_all();
    // known and unknown lines: nothing happens until the terminator
    foreach (rows[r]) begin
      for (int k = 0; k < rows[r].len; k++) u_host.send_char(rows[r].text[k]);
      chk_all();
      u_host.send_char(CH_CR);
      eB += rows[r].beeps;
      eS += rows[r].sats;
      eE += rows[r].errs;
      eL = rows[r].light;
      @(posedge mclk);
      #1;
      chk_all();
    end
    chk("replies", 8'h00, u_host.rxCount[7:0]);
    // a line feed between letters is never stored
    u_host.send_char(CH_B);
    u_host.send_char(CH_LF);
    u_host.send_char(CH_P);
    u_host.send_char(CH_CR);
    eB += 8'h01;
    @(posedge mclk);
    #1;
    chk_all();
    // steady read: four hex digits msb first, then cr lf
    u_host.send_char(CH_F);
    u_host.send_char(CH_CR);
    wait_replies(6);
    for (int i = 0; i < 6; i++) chk("steady reply", fReply[i], u_host.rxBuf[i]);
    // xoff holds the peak reply until xon
    u_host.send_char(CH_XOFF);
    u_host.send_char(CH_F);
    u_host.send_char(CH_M);
    u_host.send_char(CH_P);
    u_host.send_char(CH_CR);
    repeat (4 * BIT_LEN) @(posedge mclk);
    chk("paused replies", 8'h06, u_host.rxCount[7:0]);
    u_host.send_char(CH_XON);
    wait_replies(12);
    for (int i = 0; i < 6; i++) chk("peak reply", fmReply[i], u_host.rxBuf[i + 6]);
    chk("reply frames", 8'h00, u_host.rxBad[7:0]);
    chk_all();
    // light on, then a reset in mid-run drops it; a beep after release still works
    u_host.send_char(CH_A);
    u_host.send_char(CH_1);
    u_host.send_char(CH_CR);
    eL = 1'b1;
    @(posedge mclk);
    #1;
    chk_all();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    eL = 1'b0;
    chk("txd", 8'h01, {7'h0, txd});
    chk_all();
    u_host.send_char(CH_B);
    u_host.send_char(CH_P);
    u_host.send_char(CH_CR);
    eB += 8'h01;
    @(posedge mclk);
    #1;
    chk_all();
    report_and_stop();
  end
endmodule
